// File: hw/bprx_defs.svh
`ifndef BPRX_DEFS_SVH
`define BPRX_DEFS_SVH
// register word addresses on the plain port
`define BPRX_ADDR_CONTROL 4'h0
`define BPRX_ADDR_STATUS 4'h1
`define BPRX_ADDR_CHAN_A 4'h2
`define BPRX_ADDR_CHAN_B 4'h3
// control fields
`define BPRX_CTL_FAULT_LO 0
`define BPRX_CTL_LOCK_LO 2
`define BPRX_CTL_SIDE_SEL 4
`define BPRX_CTL_DOUBLE 5
`define BPRX_CTL_MUTE 6
`define BPRX_CTL_EXT_PLL 7
`define BPRX_CTL_SOFT_RST 9
`define BPRX_CTL_MASK 32'h000002ff
`define BPRX_CTL_RESET 32'h00000000
// status fields
`define BPRX_ST_NA_CH1 0
`define BPRX_ST_NA_CH2 1
`define BPRX_ST_NA_FRAME 2
`define BPRX_ST_VALID 3
`define BPRX_ST_LOCK 4
`define BPRX_ST_LOST 5
`define BPRX_ST_PARITY 6
`define BPRX_ST_CODING 7
`define BPRX_ST_B0A_LO 16
`define BPRX_ST_B0B_LO 24
// channel status block length in bits
`define BPRX_CS_BITS 40
// soft mute: samples shift right one bit every this many cycles plus one
`define BPRX_MUTE_STEP 8'h10
`endif

// File: hw/bprx_pkg.sv
package bprx_pkg;
	typedef enum logic [1:0] {
		bprx_act_none = 2'b00,
		bprx_act_hold = 2'b01,
		bprx_act_zero = 2'b10,
		bprx_act_soft = 2'b11
	} bprx_action_type;
	typedef enum logic [1:0] {
		bprx_out_pass = 2'b00,
		bprx_out_hold = 2'b01,
		bprx_out_zero = 2'b10,
		bprx_out_fade = 2'b11
	} bprx_out_state_type;
endpackage : bprx_pkg

// File: hw/bprx_ctrl.sv
`timescale 1ns/1ps
`include "bprx_defs.svh"
module bprx_ctrl import bprx_pkg::*; (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// decoded subframe stream from the line decoder
	input wire logic sub_valid,
	input wire logic sub_is_b,
	input wire logic [23:0] sub_sample,
	input wire logic sub_validity,
	input wire logic sub_cs_bit,
	input wire logic sub_block_start,
	input wire logic sub_non_audio,
	input wire logic parity_fault,
	input wire logic coding_fault,
	input wire logic rx_locked,
	input wire logic stream_lost,
	// output audio samples
	output logic out_valid,
	output logic out_right,
	output logic [23:0] out_sample,
	// receiver steering
	output logic external_pll_select,
	output logic single_chan_double_rate,
	output logic receiver_reset
);
	////////////////////////////////////////////////////////////////////////////
	logic [31:0] rx_control;
	logic [31:0] rx_chan_status_a;
	logic [31:0] rx_chan_status_b;
	logic [7:0] chan_stat_byte0_a;
	logic [7:0] chan_stat_byte0_b;
	logic [39:0] shift_a;
	logic [39:0] shift_b;
	logic [5:0] count_a;
	logic [5:0] count_b;
	logic parity_fault_flag;
	logic coding_fault_flag;
	logic non_audio_sub_ch1;
	logic non_audio_sub_ch2;
	logic valid_a;
	logic valid_b;
	logic [23:0] last_a;
	logic [23:0] last_b;
	logic [7:0] fade_cnt;
	logic [4:0] fade_shift;
	bprx_out_state_type out_state;
	bprx_out_state_type next_out_state;
	bprx_action_type fault_action_setting;
	bprx_action_type lock_action;
	logic rx_rst;
	logic status_read;
	logic non_audio_frame;
	logic [31:0] status_word;

	assign fault_action_setting = bprx_action_type'(rx_control[`BPRX_CTL_FAULT_LO +: 2]);
	assign lock_action = bprx_action_type'(rx_control[`BPRX_CTL_LOCK_LO +: 2]);
	// receiver logic is cleared by soft reset; control and pll select are not
	assign rx_rst = rx_control[`BPRX_CTL_SOFT_RST];
	assign status_read = reg_rd && (reg_addr == `BPRX_ADDR_STATUS);
	assign non_audio_frame = non_audio_sub_ch1 && non_audio_sub_ch2;

	function automatic logic [23:0] pick_last(input logic right);
		pick_last = right ? last_b : last_a;
	endfunction : pick_last

	function automatic logic block_done(input logic [5:0] count, input logic start);
		// true while the 40th bit is still on the input, not yet shifted in
		block_done = (count == 6'(`BPRX_CS_BITS - 1)) && !start;
	endfunction : block_done

	////////////////////////////////////////////////////////////////////////////
	// register writes
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_control <= `BPRX_CTL_RESET;
		end else if (reg_wr && reg_addr == `BPRX_ADDR_CONTROL) begin
			rx_control <= reg_wdata & `BPRX_CTL_MASK;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			external_pll_select <= 1'b0;
			single_chan_double_rate <= 1'b0;
			receiver_reset <= 1'b0;
		end else begin
			external_pll_select <= rx_control[`BPRX_CTL_EXT_PLL];
			single_chan_double_rate <= rx_control[`BPRX_CTL_DOUBLE];
			receiver_reset <= rx_rst;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sticky errors; a new event beats the clearing read
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			parity_fault_flag <= 1'b0;
			coding_fault_flag <= 1'b0;
		end else if (rx_rst) begin
			parity_fault_flag <= 1'b0;
			coding_fault_flag <= 1'b0;
		end else begin
			parity_fault_flag <= parity_fault || (parity_fault_flag && !status_read);
			coding_fault_flag <= coding_fault || (coding_fault_flag && !status_read);
		end
	end

	// per-subframe non-audio and validity, updated each subframe
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			non_audio_sub_ch1 <= 1'b0;
			non_audio_sub_ch2 <= 1'b0;
			valid_a <= 1'b0;
			valid_b <= 1'b0;
		end else if (rx_rst) begin
			non_audio_sub_ch1 <= 1'b0;
			non_audio_sub_ch2 <= 1'b0;
			valid_a <= 1'b0;
			valid_b <= 1'b0;
		end else if (sub_valid && !sub_is_b) begin
			non_audio_sub_ch1 <= sub_non_audio;
			valid_a <= sub_validity;
		end else if (sub_valid) begin
			non_audio_sub_ch2 <= sub_non_audio;
			valid_b <= sub_validity;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// channel status: shift in, commit only a full block
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			shift_a <= 40'h0;
			count_a <= 6'h0;
		end else if (rx_rst) begin
			shift_a <= 40'h0;
			count_a <= 6'h0;
		end else if (sub_valid && !sub_is_b) begin
			// bits arrive first-to-last, bit 0 of byte 0 first
			shift_a <= {sub_cs_bit, shift_a[39:1]};
			count_a <= sub_block_start ? 6'h1 : count_a + 6'h1;
		end
	end

	// a completed block outranks a software write in the same cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_chan_status_a <= 32'h0;
			chan_stat_byte0_a <= 8'h0;
		end else if (rx_rst) begin
			rx_chan_status_a <= 32'h0;
			chan_stat_byte0_a <= 8'h0;
		end else if (sub_valid && !sub_is_b && block_done(count_a, sub_block_start)) begin
			chan_stat_byte0_a <= shift_a[8:1];
			rx_chan_status_a <= {sub_cs_bit, shift_a[39:9]};
		end else if (reg_wr && reg_addr == `BPRX_ADDR_CHAN_A) begin
			rx_chan_status_a <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			shift_b <= 40'h0;
			count_b <= 6'h0;
		end else if (rx_rst) begin
			shift_b <= 40'h0;
			count_b <= 6'h0;
		end else if (sub_valid && sub_is_b) begin
			// same framing as side a
			shift_b <= {sub_cs_bit, shift_b[39:1]};
			count_b <= sub_block_start ? 6'h1 : count_b + 6'h1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_chan_status_b <= 32'h0;
			chan_stat_byte0_b <= 8'h0;
		end else if (rx_rst) begin
			rx_chan_status_b <= 32'h0;
			chan_stat_byte0_b <= 8'h0;
		end else if (sub_valid && sub_is_b && block_done(count_b, sub_block_start)) begin
			chan_stat_byte0_b <= shift_b[8:1];
			rx_chan_status_b <= {sub_cs_bit, shift_b[39:9]};
		end else if (reg_wr && reg_addr == `BPRX_ADDR_CHAN_B) begin
			rx_chan_status_b <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register reads, data one cycle after the strobe
	// zero outside the answer cycle, so the port can be or-ed with others
	always_comb begin
		status_word = 32'h0;
		status_word[`BPRX_ST_NA_CH1] = non_audio_sub_ch1;
		status_word[`BPRX_ST_NA_CH2] = non_audio_sub_ch2;
		status_word[`BPRX_ST_NA_FRAME] = non_audio_frame;
		status_word[`BPRX_ST_VALID] = valid_a | valid_b;
		status_word[`BPRX_ST_LOCK] = rx_locked;
		status_word[`BPRX_ST_LOST] = stream_lost;
		status_word[`BPRX_ST_PARITY] = parity_fault_flag;
		status_word[`BPRX_ST_CODING] = coding_fault_flag;
		status_word[`BPRX_ST_B0A_LO +: 8] = chan_stat_byte0_a;
		status_word[`BPRX_ST_B0B_LO +: 8] = chan_stat_byte0_b;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			case (reg_addr)
				`BPRX_ADDR_CONTROL: reg_rdata <= rx_control;
				`BPRX_ADDR_STATUS: reg_rdata <= status_word;
				`BPRX_ADDR_CHAN_A: reg_rdata <= rx_chan_status_a;
				`BPRX_ADDR_CHAN_B: reg_rdata <= rx_chan_status_b;
				default: reg_rdata <= 32'h0;
			endcase
		end else begin
			reg_rdata <= 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// lock-loss output state; faults on a single sample are handled per sample
	always_comb begin
		next_out_state = bprx_out_pass;
		if (!rx_locked || stream_lost) begin
			case (lock_action)
				bprx_act_none: next_out_state = bprx_out_pass;
				bprx_act_hold: next_out_state = bprx_out_hold;
				bprx_act_zero: next_out_state = bprx_out_zero;
				bprx_act_soft: begin
					// with a validity bit set on either side the data is not faded but cut
					if (valid_a | valid_b) begin
						next_out_state = bprx_out_zero;
					end else begin
						next_out_state = bprx_out_fade;
					end
				end
				default: next_out_state = bprx_out_pass;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			out_state <= bprx_out_pass;
			fade_cnt <= 8'h0;
			fade_shift <= 5'h0;
		end else if (rx_rst) begin
			out_state <= bprx_out_pass;
			fade_cnt <= 8'h0;
			fade_shift <= 5'h0;
		end else begin
			out_state <= next_out_state;
			if (next_out_state != bprx_out_fade) begin
				fade_cnt <= 8'h0;
				fade_shift <= 5'h0;
			// one bit of attenuation per step: coarse, but needs no multiplier
			end else if (fade_cnt == `BPRX_MUTE_STEP) begin
				fade_cnt <= 8'h0;
				if (fade_shift != 5'h18) begin
					fade_shift <= fade_shift + 5'h1;
				end
			end else begin
				fade_cnt <= fade_cnt + 8'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sample path; output strobes keep running while muted
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			out_valid <= 1'b0;
			out_right <= 1'b0;
			out_sample <= 24'h0;
			last_a <= 24'h0;
			last_b <= 24'h0;
		end else if (rx_rst) begin
			out_valid <= 1'b0;
			out_right <= 1'b0;
			out_sample <= 24'h0;
			last_a <= 24'h0;
			last_b <= 24'h0;
		end else begin
			// double-rate mode passes only the selected side
			out_valid <= sub_valid && (!rx_control[`BPRX_CTL_DOUBLE] ||
				(sub_is_b == rx_control[`BPRX_CTL_SIDE_SEL]));
			out_right <= sub_is_b;
			if (sub_valid && !parity_fault && !coding_fault && rx_locked && !stream_lost) begin
				if (sub_is_b) begin
					last_b <= sub_sample;
				end else begin
					last_a <= sub_sample;
				end
			end
			// mute is tested first: it must win over every recovery mode
			if (rx_control[`BPRX_CTL_MUTE]) begin
				out_sample <= 24'h0;
			end else if (out_state == bprx_out_zero || next_out_state == bprx_out_zero) begin
				out_sample <= 24'h0;
			end else if (next_out_state == bprx_out_hold) begin
				out_sample <= pick_last(sub_is_b);
			end else if (next_out_state == bprx_out_fade) begin
				out_sample <= pick_last(sub_is_b) >> fade_shift;
			end else if ((parity_fault || coding_fault) && fault_action_setting == bprx_act_hold) begin
				out_sample <= pick_last(sub_is_b);
			end else if ((parity_fault || coding_fault) && fault_action_setting == bprx_act_zero) begin
				out_sample <= 24'h0;
			end else begin
				out_sample <= sub_sample;
			end
		end
	end
endmodule : bprx_ctrl

// File: testbench/bprx_ctrl_checker.sv
`timescale 1ns/1ps
module bprx_ctrl_checker (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// stream and outputs
	input wire logic sub_valid,
	input wire logic sub_is_b,
	input wire logic parity_fault,
	input wire logic coding_fault,
	input wire logic out_valid,
	input wire logic out_right,
	input wire logic [23:0] out_sample,
	input wire logic external_pll_select,
	input wire logic single_chan_double_rate,
	input wire logic receiver_reset
);
	logic [9:0] ctl;
	logic st_rd;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// shadow of the control word, so steering can be tied to what software wrote
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			ctl <= 10'h0;
		else if (reg_wr && reg_addr == 4'h0)
			ctl <= reg_wdata[9:0];
	end
	assign st_rd = reg_rd && reg_addr == 4'h1 && !receiver_reset;
	sequence s_late_read(logic f);
		f && !ctl[9] ##1 !st_rd && !ctl[9] ##1 st_rd;
	endsequence
	a_pll_follow: assert property ($stable(ctl[7]) |-> external_pll_select == ctl[7])
		else $error("pll select wrong");
	a_mode_follow: assert property ($stable(ctl[5]) |-> single_chan_double_rate == ctl[5])
		else $error("mode wrong");
	a_soft_reset: assert property ($stable(ctl[9]) |-> receiver_reset == ctl[9])
		else $error("soft reset wrong");
	a_out_side: assert property (sub_valid && !ctl[5] && !ctl[9] && !receiver_reset |=>
		out_valid && out_right == $past(sub_is_b)) else $error("sample not passed");
	a_side_filter: assert property (sub_valid && ctl[5] && $stable(ctl[5:4]) && sub_is_b != ctl[4] |=> !out_valid)
		else $error("wrong side passed");
	a_mute_zero: assert property (out_valid && ctl[6] && $past(ctl[6]) |-> out_sample == 24'h0)
		else $error("mute leaks data");
	a_parity_sticky: assert property (s_late_read(parity_fault) |=> reg_rdata[6])
		else $error("parity flag lost");
	a_coding_sticky: assert property (s_late_read(coding_fault) |=> reg_rdata[7])
		else $error("coding flag lost");
	a_fault_in_read: assert property (s_late_read(parity_fault && st_rd) |=> reg_rdata[6])
		else $error("fault lost in read");
	a_read_clears: assert property (st_rd && !parity_fault ##1 !parity_fault ##1 st_rd && !parity_fault |=>
		!reg_rdata[6]) else $error("flag not cleared");
endmodule : bprx_ctrl_checker
bind bprx_ctrl bprx_ctrl_checker i_bprx_ctrl_checker (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .sub_valid, .sub_is_b, .parity_fault, .coding_fault, .out_valid, .out_right, .out_sample,
	.external_pll_select, .single_chan_double_rate, .receiver_reset);

// File: testbench/bprx_src.sv
`timescale 1ns/1ps
module bprx_src (
	// clock
	input wire logic clk_sys,
	// decoded subframes toward the receiver
	output logic sub_valid = 1'b0,
	output logic sub_is_b = 1'b0,
	output logic [23:0] sub_sample = 24'h0,
	output logic sub_validity = 1'b0,
	output logic sub_cs_bit = 1'b0,
	output logic sub_block_start = 1'b0,
	output logic sub_non_audio = 1'b0,
	output logic parity_fault = 1'b0,
	output logic coding_fault = 1'b0
);
	// f packs coding, parity, non-audio, block start, status bit, validity
	task automatic send(input logic b, input logic [23:0] s, input logic [5:0] f);
		@(posedge clk_sys);
		sub_valid <= 1'b1;
		{sub_is_b, sub_sample, coding_fault, parity_fault, sub_non_audio, sub_block_start, sub_cs_bit,
			sub_validity} <= {b, s, f};
		@(posedge clk_sys);
		sub_valid <= 1'b0;
		{coding_fault, parity_fault} <= 2'b00;
		// stale data between subframes, never a frozen copy
		sub_sample <= ~s;
	endtask : send
endmodule : bprx_src

// File: testbench/bprx_ctrl_tb_top.sv
`timescale 1ns/1ps
module bprx_ctrl_tb_top;
	logic clk_sys, rst, reg_wr, reg_rd, rx_locked, stream_lost;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic sub_valid, sub_is_b, sub_validity, sub_cs_bit, sub_block_start, sub_non_audio, parity_fault, coding_fault;
	logic [23:0] sub_sample, out_sample;
	logic out_valid, out_right, external_pll_select, single_chan_double_rate, receiver_reset;
	logic [23:0] ef [4] = '{24'h222222, 24'h111111, 24'h0, 24'h222222};
	logic [23:0] el [4] = '{24'h444444, 24'h333333, 24'h0, 24'h0};
	localparam logic [39:0] cs_a = 40'hc1b2a39485;
	localparam logic [39:0] cs_b = 40'h5a6b7c8d9e;
	int miscompares = 0;
	int n_tests = 0;
	bprx_ctrl i_bprx_ctrl (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sub_valid, .sub_is_b,
		.sub_sample, .sub_validity, .sub_cs_bit, .sub_block_start, .sub_non_audio, .parity_fault, .coding_fault,
		.rx_locked, .stream_lost, .out_valid, .out_right, .out_sample, .external_pll_select,
		.single_chan_double_rate, .receiver_reset);
	bprx_src i_bprx_src (.clk_sys, .sub_valid, .sub_is_b, .sub_sample, .sub_validity, .sub_cs_bit,
		.sub_block_start, .sub_non_audio, .parity_fault, .coding_fault);
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd
	task automatic rc(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		chk(d, e);
	endtask : rc
	task automatic lv(input logic l, input logic s);
		@(posedge clk_sys);
		{rx_locked, stream_lost} <= {l, s};
	endtask : lv
	// a filtered subframe only checks that nothing came out
	task automatic sc(input logic b, input logic [23:0] s, input logic [5:0] f, input logic [24:0] e);
		i_bprx_src.send(b, s, f);
		#1;
		chk({6'h0, out_right & out_valid, out_valid, out_valid ? out_sample : 24'h0},
			{6'h0, b & e[24], e[24], e[24] ? e[23:0] : 24'h0});
	endtask : sc
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test
	////////////////////////////////////////
	initial begin : main
		logic [31:0] d;
		{rst, reg_wr, reg_rd, reg_addr, reg_wdata, rx_locked, stream_lost} = {1'b1, 38'h0, 2'b10};
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		rc(4'h0, 32'h0);
		rc(4'h2, 32'h0);
		rc(4'h7, 32'h0);
		rc(4'h1, 32'h10);
		lv(1'b0, 1'b1);
		rc(4'h1, 32'h20);
		lv(1'b1, 1'b0);
		wr(4'h0, 32'hffffffff);
		rc(4'h0, 32'h2ff);
		chk({29'h0, external_pll_select, single_chan_double_rate, receiver_reset}, 32'h7);
		wr(4'h1, 32'hffffffff);
		wr(4'h0, 32'h0);
		rc(4'h1, 32'h10);
		for (int i = 0; i < 4; i++) begin
			wr(4'h0, i);
			sc(1'b0, 24'h111111, 6'h0, {1'b1, 24'h111111});
			sc(1'b0, 24'h222222, i[0] ? 6'h20 : 6'h10, {1'b1, ef[i]});
			rc(4'h1, i[0] ? 32'h90 : 32'h50);
			rc(4'h1, 32'h10);
		end
		fork
			rd(4'h1, d);
			i_bprx_src.send(1'b0, 24'h1, 6'h10);
		join
		rc(4'h1, 32'h50);
		for (int l = 0; l < 4; l++) begin
			wr(4'h0, l << 2);
			sc(1'b0, 24'h333333, {5'h0, l == 3}, {1'b1, 24'h333333});
			lv(1'b0, 1'b0);
			sc(1'b0, 24'h444444, {5'h0, l == 3}, {1'b1, el[l]});
			lv(1'b1, 1'b0);
		end
		sc(1'b0, 24'h7fffff, 6'h0, {1'b1, 24'h7fffff});
		lv(1'b0, 1'b0);
		i_bprx_src.send(1'b0, 24'h7fffff, 6'h0);
		#1;
		chk({31'h0, out_sample != 24'h0}, 32'h1);
		// fade needs 24 steps of 17 cycles to reach silence
		repeat (430) @(posedge clk_sys);
		sc(1'b0, 24'h7fffff, 6'h0, {1'b1, 24'h0});
		lv(1'b1, 1'b0);
		wr(4'h0, 32'h40);
		sc(1'b0, 24'h555555, 6'h0, {1'b1, 24'h0});
		for (int s = 0; s < 2; s++) begin
			wr(4'h0, 32'h20 | (s << 4));
			sc(1'b0, 24'h666666, 6'h0, {s == 0, 24'h666666});
			sc(1'b1, 24'h777777, 6'h0, {s == 1, 24'h777777});
		end
		wr(4'h0, 32'h0);
		sc(1'b0, 24'h1, 6'h08, {1'b1, 24'h1});
		rc(4'h1, 32'h11);
		sc(1'b1, 24'h2, 6'h09, {1'b1, 24'h2});
		rc(4'h1, 32'h1f);
		for (int i = 0; i < 40; i++) begin
			sc(1'b0, 24'h0, {3'h0, i == 0, cs_a[i], 1'b0}, 25'h1000000);
			sc(1'b1, 24'h0, {3'h0, i == 0, cs_b[i], 1'b0}, 25'h1000000);
			if (i == 20)
				rc(4'h2, 32'h0);
		end
		rc(4'h2, cs_a[39:8]);
		rc(4'h3, cs_b[39:8]);
		rc(4'h1, {cs_b[7:0], cs_a[7:0], 16'h0010});
		wr(4'h2, 32'h5a5aa5a5);
		rc(4'h2, 32'h5a5aa5a5);
		wr(4'h0, 32'h280);
		rc(4'h3, 32'h0);
		chk({31'h0, external_pll_select}, 32'h1);
		wr(4'h0, 32'h0);
		stop_test();
	end
endmodule : bprx_ctrl_tb_top
